// ===== hdl/dpt_pkg.sv
// Constants shared by the DDR3 PHY initialisation and training block
package dpt_pkg;

  localparam int CLK_MHZ        = 40;
  localparam int CLK_PERIOD_NS  = 25;

  // Memory power-up reset wait
  localparam int RST_WAIT_US    = 200;
  localparam int RST_WAIT_CYC   = RST_WAIT_US * CLK_MHZ;

  // Spacing between mode register commands, a least time
  localparam int CMD_GAP_NS     = 100;
  localparam int CMD_GAP_CYC    =
    (CMD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Settle time after each leveling strobe, a least time
  localparam int WL_SETTLE_NS   = 50;
  localparam int WL_SETTLE_CYC  =
    (WL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Read command to gate rise, and gate length (burst of four)
  localparam int RD_LAT_CYC     = 4;
  localparam int BURST_CYC      = 2;

  // Memory command codes
  localparam logic [2:0] CMD_NOP  = 3'h0;
  localparam logic [2:0] CMD_MRS  = 3'h1;
  localparam logic [2:0] CMD_ZQCL = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h3;
  localparam logic [2:0] CMD_WLEV = 3'h4;
  localparam int         INIT_CMDS = 5;

  // APB register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_TRIALS = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_WLDLY  = 8'h0C;
  localparam logic [7:0] REG_PHASE  = 8'h10;

  // Control fields and reset values
  localparam int         CTRL_WL_EN    = 0;
  localparam logic       CTRL_WL_EN_RST = 1'b1;
  localparam int         TRIALS_W      = 4;
  localparam logic [3:0] TRIALS_RST    = 4'h4;

  // Status bit positions
  localparam int ST_CLK_READY = 0;
  localparam int ST_INIT_ACT  = 1;
  localparam int ST_WL_ACT    = 2;
  localparam int ST_COMPLETE  = 3;
  localparam int ST_WRITE_LEVEL_ERROR    = 4;
  localparam int ST_RT_ERR    = 5;
  localparam int ST_RST_DONE  = 6;

  localparam int PHASE_W = 3;
  localparam int GATE_W  = 4;

  typedef enum logic [6:0] {
    DPT_IDLE = 7'b0000001,
    DPT_RSTW = 7'b0000010,
    DPT_MRS  = 7'b0000100,
    DPT_WLEV = 7'b0001000,
    DPT_RTRN = 7'b0010000,
    DPT_UPD  = 7'b0100000,
    DPT_DONE = 7'b1000000
  } dpt_state_e;

endpackage

// ===== hdl/dpt_phy_init.sv
// DDR3 PHY initialisation, leveling, read training and data paths
`timescale 1ns/1ps
module dpt_phy_init #(
  parameter int DQ_W         = 16,
  parameter int GEAR_RATIO   = 2,
  parameter int DLY_W        = 4,
  parameter int RST_WAIT_CYC = dpt_pkg::RST_WAIT_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      clk_stable,
  output logic                           csm_ready,
  output logic                           io_gear_4to1,
  output logic                           dll_update,
  input  wire logic                      update_done,
  input  wire logic                      init_start,
  input  wire logic                      freq_ratio,
  input  wire logic                      data_byte_disable,
  output logic                           init_complete,
  output logic                           init_active,
  output logic                           wl_active,
  output logic                           write_level_error,
  output logic                           read_train_error,
  output logic                           reset_count_done,
  output logic                           mem_rst_n,
  input  wire logic [2:0]                ctl_cmd,
  input  wire logic                      ctl_cmd_valid,
  output logic [2:0]                     mem_cmd,
  output logic                           mem_cmd_valid,
  output logic [DQ_W/8-1:0]              wl_strobe,
  output logic [DQ_W/8*DLY_W-1:0]        wl_delay,
  input  wire logic [DQ_W/8-1:0]         wl_feedback,
  output logic [3:0]                     read_gate,
  output logic [DQ_W/8*3-1:0]            read_gate_phase_select,
  input  wire logic [DQ_W/8-1:0]         burst_detect_flag,
  input  wire logic                      wrdata_en,
  input  wire logic [4*DQ_W-1:0]         wrdata,
  input  wire logic [DQ_W/2-1:0]         wrdata_mask,
  output logic                           io_wr_en,
  output logic [4*DQ_W-1:0]              io_wrdata,
  output logic [DQ_W/2-1:0]              io_wrmask,
  input  wire logic                      rddata_en,
  input  wire logic [4*DQ_W-1:0]         io_rddata,
  input  wire logic [DQ_W/8-1:0]         read_window_valid,
  output logic [4*DQ_W-1:0]              rddata,
  output logic                           rddata_valid
);

  localparam int G   = DQ_W / 8;
  localparam int GW  = (G > 1) ? $clog2(G) : 1;
  localparam int PW  = dpt_pkg::PHASE_W;
  localparam int CW  = 16;
  localparam int RW  = $clog2(RST_WAIT_CYC + 1);
  localparam logic [DLY_W-1:0] DLY_MAX = {DLY_W{1'b1}};
  localparam logic [PW-1:0]    PH_MAX  = {PW{1'b1}};

  initial begin
    if (DQ_W != 8 && DQ_W != 16 && DQ_W != 32)
      $error("DQ_W must be 8, 16 or 32");
    if (GEAR_RATIO != 2 && GEAR_RATIO != 4)
      $error("GEAR_RATIO must be 2 or 4");
    if (G * DLY_W > 32 || RST_WAIT_CYC < 1)
      $error("Delay fields or reset wait out of range");
  end

  function automatic logic [2:0] init_cmd(input logic [2:0] idx);
    init_cmd = (idx == 3'h4) ? dpt_pkg::CMD_ZQCL : dpt_pkg::CMD_MRS;
  endfunction

  // clk_stable, update_done and wl_feedback pass two flops before use
  logic          stab_s1_r, stab_s2_r;
  logic          upd_s1_r, upd_s2_r;
  logic [G-1:0]  wlfb_s1_r, wlfb_s2_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stab_s1_r <= 1'b0;
      stab_s2_r <= 1'b0;
      upd_s1_r  <= 1'b0;
      upd_s2_r  <= 1'b0;
      wlfb_s1_r <= '0;
      wlfb_s2_r <= '0;
    end else begin
      stab_s1_r <= clk_stable;
      stab_s2_r <= stab_s1_r;
      upd_s1_r  <= update_done;
      upd_s2_r  <= upd_s1_r;
      wlfb_s1_r <= wl_feedback;
      wlfb_s2_r <= wlfb_s1_r;
    end
  end

  // Sequencer state
  dpt_pkg::dpt_state_e state_r;
  logic [RW-1:0]        rst_cnt_r;
  logic [CW-1:0]        tmr_r;
  logic [2:0]           idx_r;
  logic [GW-1:0]        grp_r;
  logic [1:0]           sub_r;
  logic [3:0]           trial_r;
  logic                 seen_low_r;
  logic                 start_d_r;
  logic                 write_level_error_r, rt_err_r;
  logic [DLY_W-1:0]     dly_r   [G];
  logic [PW-1:0]        phase_r [G];
  logic                 wl_en_r;
  logic [3:0]           trials_r;

  // Gate generator shared by training and normal reads
  logic [dpt_pkg::RD_LAT_CYC-1:0] rd_sr_r;
  logic [1:0]                     gate_cnt_r;
  logic                           gate_on_r;

  wire start_rise  = init_start & ~start_d_r;
  wire train_fire  = (state_r == dpt_pkg::DPT_RTRN) && (sub_r == 2'h0);
  wire norm_fire   = (state_r == dpt_pkg::DPT_DONE) && rddata_en;
  wire gate_end    = gate_on_r && (gate_cnt_r == 2'h1);
  wire [3:0] trials_eff = (trials_r == 4'h0) ? 4'h1 : trials_r;
  wire last_grp    = (grp_r == GW'(G - 1));
  wire burst_ok    = burst_detect_flag[grp_r];
  wire fb_now      = wlfb_s2_r[grp_r];
  wire tmr_zero    = (tmr_r == '0);
  // write_level_error and read_train_error fall with complete, so neither is seen without it
  wire done_hold   = (state_r == dpt_pkg::DPT_DONE) && !start_rise;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_sr_r    <= '0;
      gate_cnt_r <= 2'h0;
      gate_on_r  <= 1'b0;
    end else begin
      rd_sr_r <= {rd_sr_r[dpt_pkg::RD_LAT_CYC-2:0],
                  train_fire | norm_fire};
      if (rd_sr_r[dpt_pkg::RD_LAT_CYC-1]) begin
        gate_cnt_r <= 2'(dpt_pkg::BURST_CYC);
        gate_on_r  <= 1'b1;
      end else if (gate_on_r) begin
        gate_cnt_r <= gate_cnt_r - 2'h1;
        gate_on_r  <= (gate_cnt_r != 2'h1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= dpt_pkg::DPT_IDLE;
      rst_cnt_r  <= '0;
      tmr_r      <= '0;
      idx_r      <= 3'h0;
      grp_r      <= '0;
      sub_r      <= 2'h0;
      trial_r    <= 4'h0;
      seen_low_r <= 1'b0;
      start_d_r  <= 1'b0;
      write_level_error_r   <= 1'b0;
      rt_err_r   <= 1'b0;
      for (int i = 0; i < G; i++) begin
        dly_r[i]   <= '0;
        phase_r[i] <= '0;
      end
    end else begin
      start_d_r <= init_start;
      if (!tmr_zero)
        tmr_r <= tmr_r - CW'(1);
      case (state_r)
        dpt_pkg::DPT_IDLE: begin
          if (start_rise && stab_s2_r) begin
            state_r   <= dpt_pkg::DPT_RSTW;
            rst_cnt_r <= RW'(RST_WAIT_CYC);
          end
        end
        dpt_pkg::DPT_RSTW: begin
          if (rst_cnt_r == '0) begin
            state_r <= dpt_pkg::DPT_MRS;
            idx_r   <= 3'h0;
          end else begin
            rst_cnt_r <= rst_cnt_r - RW'(1);
          end
        end
        dpt_pkg::DPT_MRS: begin
          if (tmr_zero) begin
            if (idx_r == 3'(dpt_pkg::INIT_CMDS)) begin
              write_level_error_r   <= 1'b0;
              rt_err_r   <= 1'b0;
              grp_r      <= '0;
              seen_low_r <= 1'b0;
              sub_r      <= 2'h0;
              trial_r    <= 4'h0;
              for (int i = 0; i < G; i++) begin
                dly_r[i]   <= '0;
                phase_r[i] <= '0;
              end
              // Leveling skipped when software disabled it
              state_r <= wl_en_r ? dpt_pkg::DPT_WLEV
                                 : dpt_pkg::DPT_RTRN;
            end else begin
              idx_r <= idx_r + 3'h1;
              tmr_r <= CW'(dpt_pkg::CMD_GAP_CYC);
            end
          end
        end
        dpt_pkg::DPT_WLEV: begin
          // Strobe, let feedback settle, then look for 0 to 1
          if (sub_r == 2'h0) begin
            sub_r <= 2'h1;
            tmr_r <= CW'(dpt_pkg::WL_SETTLE_CYC);
          end else if (tmr_zero) begin
            sub_r <= 2'h0;
            if (fb_now && seen_low_r) begin
              seen_low_r <= 1'b0;
              if (last_grp) begin
                state_r <= dpt_pkg::DPT_RTRN;
                grp_r   <= '0;
              end else begin
                grp_r <= grp_r + GW'(1);
              end
            end else if (dly_r[grp_r] == DLY_MAX) begin
              write_level_error_r   <= 1'b1;
              seen_low_r <= 1'b0;
              if (last_grp) begin
                state_r <= dpt_pkg::DPT_RTRN;
                grp_r   <= '0;
              end else begin
                grp_r <= grp_r + GW'(1);
              end
            end else begin
              seen_low_r   <= seen_low_r | ~fb_now;
              dly_r[grp_r] <= dly_r[grp_r] + DLY_W'(1);
            end
          end
        end
        dpt_pkg::DPT_RTRN: begin
          if (sub_r == 2'h0) begin
            sub_r <= 2'h1;
          end else if (gate_end) begin
            sub_r <= 2'h0;
            if (burst_ok && trial_r + 4'h1 == trials_eff) begin
              trial_r <= 4'h0;
              if (last_grp)
                state_r <= dpt_pkg::DPT_UPD;
              else
                grp_r <= grp_r + GW'(1);
            end else if (burst_ok) begin
              trial_r <= trial_r + 4'h1;
            end else begin
              // A miss restarts the trials one phase later; at PH_MAX it flags an error instead
              trial_r <= 4'h0;
              if (phase_r[grp_r] == PH_MAX) begin
                rt_err_r <= 1'b1;
                if (last_grp)
                  state_r <= dpt_pkg::DPT_UPD;
                else
                  grp_r <= grp_r + GW'(1);
              end else begin
                phase_r[grp_r] <= phase_r[grp_r] + PW'(1);
              end
            end
          end
        end
        dpt_pkg::DPT_UPD: begin
          if (upd_s2_r && dll_update)
            state_r <= dpt_pkg::DPT_DONE;
        end
        dpt_pkg::DPT_DONE: begin
          // A fresh start re-runs init; memory reset wait is skipped
          if (start_rise) begin
            state_r <= dpt_pkg::DPT_MRS;
            idx_r   <= 3'h0;
          end
        end
        default: state_r <= dpt_pkg::DPT_IDLE;
      endcase
    end
  end

  // Memory command issue
  wire wl_strobe_now = (state_r == dpt_pkg::DPT_WLEV) && (sub_r == 2'h0);
  wire mrs_now = (state_r == dpt_pkg::DPT_MRS) && tmr_zero &&
                 (idx_r != 3'(dpt_pkg::INIT_CMDS));
  wire [2:0] cmd_nxt = mrs_now    ? init_cmd(idx_r) :
                       train_fire ? dpt_pkg::CMD_READ :
                       (state_r == dpt_pkg::DPT_DONE) ? ctl_cmd :
                       dpt_pkg::CMD_NOP;
  wire cmd_v_nxt = mrs_now | train_fire |
                   ((state_r == dpt_pkg::DPT_DONE) & ctl_cmd_valid);

  // Deskew: each lane is held until every lane has seen its window
  logic [4*DQ_W-1:0] rd_hold_r;
  logic [G-1:0]      got_r;
  wire  [G-1:0]      have = got_r | read_window_valid;
  wire               all_in = &have;
  wire  [4*DQ_W-1:0] lane_mux;

  genvar gi;
  generate
    for (gi = 0; gi < G; gi++) begin : g_lane
      assign lane_mux[gi*32 +: 32] = read_window_valid[gi] ?
             io_rddata[gi*32 +: 32] : rd_hold_r[gi*32 +: 32];
      assign wl_delay[gi*DLY_W +: DLY_W] = dly_r[gi];
      assign read_gate_phase_select[gi*3 +: 3] = phase_r[gi];
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_hold_r    <= '0;
      got_r        <= '0;
      rddata       <= '0;
      rddata_valid <= 1'b0;
    end else begin
      rd_hold_r    <= lane_mux;
      got_r        <= all_in ? '0 : have;
      rddata_valid <= all_in & (state_r == dpt_pkg::DPT_DONE);
      if (all_in)
        rddata <= lane_mux;
    end
  end

  // APB slave; registers ready one cycle after setup
  localparam int TRIALS_W_M1 = dpt_pkg::TRIALS_W - 1;
  logic [31:0] rdata_nxt;
  wire setup   = psel & ~penable;
  wire acc_wr  = psel & penable & pready & pwrite;
  wire hit_ctl = (paddr == dpt_pkg::REG_CTRL);
  wire hit_trl = (paddr == dpt_pkg::REG_TRIALS);
  wire hit_st  = (paddr == dpt_pkg::REG_STATUS);
  wire hit_wl  = (paddr == dpt_pkg::REG_WLDLY);
  wire hit_ph  = (paddr == dpt_pkg::REG_PHASE);
  wire mapped  = hit_ctl | hit_trl | hit_st | hit_wl | hit_ph;
  wire [31:0] status_w = 32'(
      {reset_count_done, rt_err_r, write_level_error_r, init_complete,
       wl_active, init_active, csm_ready});

  always_comb begin
    rdata_nxt = 32'h0;
    if (hit_ctl)
      rdata_nxt[dpt_pkg::CTRL_WL_EN] = wl_en_r;
    if (hit_trl)
      rdata_nxt[TRIALS_W_M1:0] = trials_r;
    if (hit_st)
      rdata_nxt = status_w;
    if (hit_wl)
      rdata_nxt = 32'(wl_delay);
    if (hit_ph)
      rdata_nxt = 32'(read_gate_phase_select);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0;
      wl_en_r  <= dpt_pkg::CTRL_WL_EN_RST;
      trials_r <= dpt_pkg::TRIALS_RST;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite) ? rdata_nxt : 32'h0;
      if (acc_wr && hit_ctl)
        wl_en_r <= pwdata[dpt_pkg::CTRL_WL_EN];
      if (acc_wr && hit_trl)
        trials_r <= pwdata[TRIALS_W_M1:0];
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csm_ready         <= 1'b0;
      io_gear_4to1      <= 1'b0;
      dll_update        <= 1'b0;
      init_complete     <= 1'b0;
      init_active       <= 1'b0;
      wl_active         <= 1'b0;
      write_level_error <= 1'b0;
      read_train_error  <= 1'b0;
      reset_count_done  <= 1'b0;
      mem_rst_n         <= 1'b0;
      mem_cmd           <= dpt_pkg::CMD_NOP;
      mem_cmd_valid     <= 1'b0;
      wl_strobe         <= '0;
      read_gate         <= 4'h0;
      io_wr_en          <= 1'b0;
      io_wrdata         <= '0;
      io_wrmask         <= '0;
    end else begin
      csm_ready     <= stab_s2_r;
      // Gear select; all eclk crossing is inside the I/O cells
      io_gear_4to1  <= (GEAR_RATIO == 4);
      dll_update    <= (state_r == dpt_pkg::DPT_UPD) &&
                       !(upd_s2_r && dll_update);
      init_complete <= done_hold;
      init_active   <= !(state_r == dpt_pkg::DPT_IDLE ||
                         state_r == dpt_pkg::DPT_DONE);
      wl_active     <= (state_r == dpt_pkg::DPT_WLEV);
      write_level_error <= write_level_error_r & done_hold;
      read_train_error  <= rt_err_r & done_hold;
      if (state_r == dpt_pkg::DPT_RSTW && rst_cnt_r == '0)
        reset_count_done <= 1'b1;
      if (state_r == dpt_pkg::DPT_RSTW && rst_cnt_r == '0)
        mem_rst_n <= 1'b1;
      mem_cmd       <= wl_strobe_now ? dpt_pkg::CMD_WLEV : cmd_nxt;
      mem_cmd_valid <= cmd_v_nxt | wl_strobe_now;
      wl_strobe     <= wl_strobe_now ? G'(1) << grp_r : '0;
      read_gate     <= gate_on_r ? {dpt_pkg::GATE_W{1'b1}} : 4'h0;
      io_wr_en      <= wrdata_en;
      io_wrdata     <= wrdata;
      io_wrmask     <= wrdata_mask;
    end
  end

endmodule // dpt_phy_init

// ===== testbench/dpt_phy_init_chk.sv
// Property checker for the DDR3 PHY init and training block
`timescale 1ns/1ps
module dpt_phy_init_chk #(
  parameter int DQ_W       = 16,
  parameter int GEAR_RATIO = 2
) (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pready,
  input wire logic                   clk_stable,
  input wire logic                   csm_ready,
  input wire logic                   io_gear_4to1,
  input wire logic                   dll_update,
  input wire logic                   update_done,
  input wire logic                   init_complete,
  input wire logic                   wl_active,
  input wire logic                   write_level_error,
  input wire logic                   read_train_error,
  input wire logic [3:0]             read_gate,
  input wire logic                   wrdata_en,
  input wire logic [4*DQ_W-1:0]      wrdata,
  input wire logic                   io_wr_en,
  input wire logic [4*DQ_W-1:0]      io_wrdata,
  input wire logic [DQ_W/8-1:0]      read_window_valid,
  input wire logic                   rddata_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence setup_sq;
    psel && !penable;
  endsequence
  // Gate spans the whole burst of four, then drops
  sequence gate_sq;
    (read_gate == 4'hF) [*2] ##1 (read_gate == 4'h0);
  endsequence
  AST_APB_READY: assert property (setup_sq |=> pready)
    else $error("no ready after setup");
  AST_CSM_READY: assert property (csm_ready |-> $past(clk_stable, 3))
    else $error("clock ready before clock stable");
  AST_GEAR: assert property ($past(rstn) |-> io_gear_4to1 == (GEAR_RATIO == 4))
    else $error("gearing output wrong");
  AST_ERR_WITH_DONE: assert property (
    (write_level_error || read_train_error) |-> init_complete)
    else $error("error flag without complete");
  AST_DONE_IDLE: assert property (
    init_complete |-> !wl_active && !dll_update)
    else $error("complete while a step still runs");
  AST_UPD_HOLD: assert property (dll_update && !update_done |=> dll_update)
    else $error("update request dropped early");
  AST_UPD_DROP: assert property ($fell(dll_update) |-> $past(update_done, 2))
    else $error("update request dropped without done");
  AST_WR_PIPE: assert property (
    wrdata_en |=> io_wr_en && io_wrdata == $past(wrdata))
    else $error("write data not passed in one cycle");
  AST_GATE: assert property ($rose(read_gate == 4'hF) |-> gate_sq)
    else $error("read gate shape wrong");
  AST_RD_OUT: assert property (
    rddata_valid |-> $past(|read_window_valid))
    else $error("read valid without lane valid");
endmodule // dpt_phy_init_chk

bind dpt_phy_init dpt_phy_init_chk #(.DQ_W(DQ_W), .GEAR_RATIO(GEAR_RATIO))
  i_chk (.clk, .rstn, .psel, .penable, .pready, .clk_stable, .csm_ready,
         .io_gear_4to1, .dll_update, .update_done, .init_complete, .wl_active,
         .write_level_error, .read_train_error, .read_gate, .wrdata_en,
         .wrdata, .io_wr_en, .io_wrdata, .read_window_valid, .rddata_valid);

// ===== testbench/dpt_io_model.sv
// Model of the memory, strobe buffer and clock logic beside the block
`timescale 1ns/1ps
module dpt_io_model #(
  parameter int G     = 2,
  parameter int DLY_W = 4
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               wl_fail,
  input  wire logic               rt_fail,
  input  wire logic               upd_slow,
  input  wire logic               dll_update,
  output logic                    update_done,
  input  wire logic [G*DLY_W-1:0] wl_delay,
  output logic      [G-1:0]       wl_feedback,
  input  wire logic [3:0]         read_gate,
  input  wire logic [G*3-1:0]     read_gate_phase_select,
  output logic      [G-1:0]       burst_detect_flag
);
  logic [1:0] upd_cnt_r;
  // Feedback follows the delay unless wl_fail holds it low, so a lock point exists per group
  always_comb begin
    for (int g = 0; g < G; g++) begin
      wl_feedback[g] = !wl_fail && wl_delay[g*DLY_W +: DLY_W] >= 4'h5;
      burst_detect_flag[g] = !rt_fail && read_gate == 4'hF &&
        read_gate_phase_select[g*3 +: 3] >= 3'h3;
    end
  end
  // Slow mode answers late; done then holds until the request drops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upd_cnt_r   <= 2'h0;
      update_done <= 1'b0;
    end else begin
      upd_cnt_r   <= dll_update ? upd_cnt_r + 2'h1 : 2'h0;
      update_done <= dll_update && (update_done || !upd_slow ||
                     upd_cnt_r == 2'h3);
    end
  end
endmodule // dpt_io_model

// ===== testbench/test_ddr3_phy_init_leveling_training.sv
// Self-checking bench for the DDR3 PHY init and training block
`timescale 1ns/1ps
module test_ddr3_phy_init_leveling_training;
  localparam int DQ_W = 16;
  localparam int G    = DQ_W / 8;
  logic              clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              clk_stable, csm_ready, io_gear_4to1, dll_update;
  logic              update_done, init_start, freq_ratio, data_byte_disable;
  logic              init_complete, init_active, wl_active, saw_wl;
  logic              write_level_error, read_train_error, reset_count_done;
  logic              mem_rst_n, ctl_cmd_valid, mem_cmd_valid, wrdata_en;
  logic              io_wr_en, rddata_en, rddata_valid;
  logic              wl_fail, rt_fail, upd_slow;
  logic [2:0]        ctl_cmd, mem_cmd;
  logic [3:0]        read_gate;
  logic [G-1:0]      wl_strobe, wl_feedback, burst_detect_flag;
  logic [G-1:0]      read_window_valid;
  logic [G*4-1:0]    wl_delay;
  logic [G*3-1:0]    read_gate_phase_select;
  logic [4*DQ_W-1:0] wrdata, io_wrdata, io_rddata, rddata;
  logic [DQ_W/2-1:0] wrdata_mask, io_wrmask;
  int                miscompares, checks_done;

  // Short reset wait keeps the run brief
  dpt_phy_init #(.DQ_W(DQ_W), .RST_WAIT_CYC(10)) i_dut (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .clk_stable, .csm_ready, .io_gear_4to1, .dll_update,
    .update_done, .init_start, .freq_ratio, .data_byte_disable,
    .init_complete, .init_active, .wl_active, .write_level_error,
    .read_train_error, .reset_count_done, .mem_rst_n, .ctl_cmd,
    .ctl_cmd_valid, .mem_cmd, .mem_cmd_valid, .wl_strobe, .wl_delay,
    .wl_feedback, .read_gate, .read_gate_phase_select, .burst_detect_flag,
    .wrdata_en, .wrdata, .wrdata_mask, .io_wr_en, .io_wrdata, .io_wrmask,
    .rddata_en, .io_rddata, .read_window_valid, .rddata, .rddata_valid);

  dpt_io_model #(.G(G)) i_mem (
    .clk, .rstn, .wl_fail, .rt_fail, .upd_slow, .dll_update, .update_done,
    .wl_delay, .wl_feedback, .read_gate, .read_gate_phase_select,
    .burst_detect_flag);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Values read right after an edge are those sampled at that edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp_d,
                     input logic exp_err);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    if (!wr) chk(64'(prdata), 64'(exp_d));
    chk(64'(pslverr), 64'(exp_err));
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic run_init();
    int n;
    init_start <= 1'b1;
    saw_wl = 1'b0;
    repeat (3) @(posedge clk);
    init_start <= 1'b0;
    n = 0;
    while (init_complete !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
      if (wl_active === 1'b1) saw_wl = 1'b1;
    end
    if (init_complete !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {clk_stable, init_start, freq_ratio, data_byte_disable} = '0;
    {ctl_cmd, ctl_cmd_valid, wrdata_en, wrdata, wrdata_mask} = '0;
    {rddata_en, io_rddata, read_window_valid} = '0;
    {wl_fail, rt_fail, upd_slow} = 3'h1;
    miscompares = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rstn       <= 1'b1;
    clk_stable <= 1'b1;
    apb(1'b0, dpt_pkg::REG_CTRL, 32'h0, 32'h1, 1'b0);
    apb(1'b0, dpt_pkg::REG_TRIALS, 32'h0, 32'h4, 1'b0);
    apb(1'b1, dpt_pkg::REG_TRIALS, 32'h2, 32'h0, 1'b0);
    apb(1'b0, dpt_pkg::REG_TRIALS, 32'h0, 32'h2, 1'b0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    $display("test registers done");
    run_init();
    chk(64'({write_level_error, read_train_error, saw_wl}), 64'h1);
    chk(64'({mem_rst_n, init_active, wl_delay}), 64'h255);
    chk(64'(read_gate_phase_select), 64'h1B);
    apb(1'b0, dpt_pkg::REG_PHASE, 32'h0, 32'h1B, 1'b0);
    apb(1'b0, dpt_pkg::REG_STATUS, 32'h0, 32'h49, 1'b0);
    $display("test init done");
    wrdata_en     <= 1'b1;
    wrdata        <= 64'h0123_4567_89AB_CDEF;
    wrdata_mask   <= 8'hC3;
    ctl_cmd       <= dpt_pkg::CMD_READ;
    ctl_cmd_valid <= 1'b1;
    rddata_en     <= 1'b1;
    @(posedge clk);
    {wrdata_en, ctl_cmd_valid, rddata_en} <= 3'h0;
    read_window_valid <= 2'h2;
    io_rddata         <= 64'hA5A5_5A5A_0F0F_F0F0;
    @(posedge clk);
    chk(io_wrdata, 64'h0123_4567_89AB_CDEF);
    chk(64'({io_wr_en, io_wrmask}), 64'h1C3);
    chk(64'({mem_cmd_valid, mem_cmd}), 64'hB);
    read_window_valid <= 2'h0;
    io_rddata         <= 64'h5A5A_A5A5_F0F0_0F0F;
    @(posedge clk);
    read_window_valid <= 2'h1;
    io_rddata         <= 64'h5A5A_A5A5_1234_5678;
    @(posedge clk);
    read_window_valid <= 2'h0;
    io_rddata         <= 64'hA5A5_5A5A_EDCB_A987;
    @(posedge clk);
    chk(64'(rddata_valid), 64'h1);
    chk(rddata, 64'hA5A5_5A5A_1234_5678);
    $display("test data paths done");
    apb(1'b1, dpt_pkg::REG_CTRL, 32'h0, 32'h0, 1'b0);
    {rt_fail, upd_slow, freq_ratio, data_byte_disable} <= 4'hB;
    run_init();
    chk(64'({write_level_error, read_train_error, saw_wl}), 64'h2);
    apb(1'b1, dpt_pkg::REG_CTRL, 32'h1, 32'h0, 1'b0);
    {wl_fail, rt_fail, upd_slow} <= 3'h5;
    run_init();
    chk(64'(write_level_error), 64'h1);
    $display("test failures done");
    tally_and_finish();
  end
endmodule // test_ddr3_phy_init_leveling_training
